// file: pif_irq_flags.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
// Contract
// (R1) Second enable register holds only bit 0; bits 7..1 read zero.
// (R2) Request flags set on their event whatever the enables are.
// (R3) Software clears a flag before setting its enable.
// (R4) Request one bit 7: writable gate flag, one while gate inactive. Code ignores gate_inactive_i; bit 7 changes only by write.
// (R5) Bit 6 sets on conversion done, stays until software clears.
// (R6) Bit 5 read-only, high while receive data held, cleared by rx read.
// (R7) Bit 4 read-only, high while transmit empty, cleared by tx write.
// (R8) Bit 3 sets on sync serial done, software clears.
// (R9) Bit 2 sets on capture or compare, unused in pulse-width mode.
// (R10) Bit 1 sets on timer two period match, software clears.
// (R11) Bit 0 sets on timer one overflow, software clears.
// (R12) Second request register bit 0 is unit two capture/compare flag.
// (R13) Peripheral interrupts need the peripheral enable bit too.
// (R14) Request is OR of flag AND enable, gated by both enables.
module pif_irq_flags
  import pif_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       gate_inactive_i,
  input  wire logic       conv_done_i,
  input  wire logic       rx_data_held_i,
  input  wire logic       tx_data_wr_i,
  input  wire logic       rx_data_rd_i,
  input  wire logic       sync_done_i,
  input  wire logic       capcmp_one_i,
  input  wire logic       capcmp_one_pwm_i,
  input  wire logic       t2_match_i,
  input  wire logic       t1_ovf_i,
  input  wire logic       capcmp_two_i,
  input  wire logic       capcmp_two_pwm_i,
  output logic            periph_req_o,
  output logic            irq_o
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] core_ctrl_q, core_ctrl_d;
  logic [7:0] en_one_q,    en_one_d;
  logic [7:0] en_two_q,    en_two_d;
  logic [7:0] req_one_q,   req_one_d;
  logic [7:0] req_two_q,   req_two_d;
  logic       tx_empty_q,  tx_empty_d;
  logic       rx_full_q,   rx_full_d;
  logic [1:0] stat_q,      stat_d;
  logic [1:0] mask_q,      mask_d;
  logic [7:0] rdata_q,     rdata_d;
  logic       req_q,       req_d;
  logic       irq_q,       irq_d;

  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] r, input logic w);
    return w && (a == r);
  endfunction : wr_hit

  logic [7:0] set_one;
  logic [7:0] req_one_view;
  logic       set_two;
  logic       any_req;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    core_ctrl_d = core_ctrl_q;
    en_one_d    = en_one_q;
    en_two_d    = en_two_q;
    req_one_d   = req_one_q;
    req_two_d   = req_two_q;
    stat_d      = stat_q;
    mask_d      = mask_q;
    rdata_d     = PIF_RST_BYTE;
    // Events raise flags with no regard for any enable
    set_one = PIF_RST_BYTE; // R2
    set_one[PIF_BIT_CONV_DONE]  = conv_done_i; // R5
    set_one[PIF_BIT_SYNC_DONE]  = sync_done_i; // R8
    set_one[PIF_BIT_CAPCMP_ONE] = capcmp_one_i && !capcmp_one_pwm_i; // R9
    set_one[PIF_BIT_T2_MATCH]   = t2_match_i; // R10
    set_one[PIF_BIT_T1_OVF]     = t1_ovf_i; // R11
    set_two = capcmp_two_i && !capcmp_two_pwm_i; // R12
    // Receive flag follows the buffer; a read drops it for that cycle only, then it follows rx_data_held_i again
    rx_full_d = rx_data_rd_i ? 1'b0 : rx_data_held_i; // R6
    // Transmit flag drops on data write, returns in the next cycle without a write
    tx_empty_d = !tx_data_wr_i; // R7
    if (wr_hit(addr_i, PIF_ADDR_CORE_CTRL, wr_i)) begin
      core_ctrl_d = wdata_i;
    end
    if (wr_hit(addr_i, PIF_ADDR_EN_ONE, wr_i)) begin
      en_one_d = wdata_i;
    end
    if (wr_hit(addr_i, PIF_ADDR_EN_TWO, wr_i)) begin
      en_two_d = wdata_i & PIF_EN_TWO_WMASK; // R1
    end
    if (wr_hit(addr_i, PIF_ADDR_REQ_ONE, wr_i)) begin
      req_one_d = wdata_i & PIF_REQ_ONE_WMASK; // R4
    end
    if (wr_hit(addr_i, PIF_ADDR_REQ_TWO, wr_i)) begin
      req_two_d = wdata_i & PIF_REQ_TWO_WMASK;
    end
    // Set wins over a clearing write in the same cycle
    req_one_d = req_one_d | set_one; // R2
    req_two_d[PIF_BIT_CAPCMP_TWO] = req_two_d[PIF_BIT_CAPCMP_TWO] | set_two; // R12
    if (wr_hit(addr_i, PIF_ADDR_IRQ_MASK, wr_i)) begin
      mask_d = wdata_i[1:0];
    end
    if (wr_hit(addr_i, PIF_ADDR_IRQ_STAT, wr_i)) begin
      stat_d = stat_q & ~wdata_i[1:0];
    end
    stat_d = stat_d | {set_two, |set_one};
    req_one_view = req_one_q;
    req_one_view[PIF_BIT_RX_FULL]  = rx_full_q; // R6
    req_one_view[PIF_BIT_TX_EMPTY] = tx_empty_q; // R7
    if (rd_i) begin
      unique case (addr_i)
        PIF_ADDR_CORE_CTRL: rdata_d = core_ctrl_q;
        PIF_ADDR_EN_ONE:    rdata_d = en_one_q;
        PIF_ADDR_EN_TWO:    rdata_d = en_two_q; // R1
        PIF_ADDR_REQ_ONE:   rdata_d = req_one_view;
        PIF_ADDR_REQ_TWO:   rdata_d = req_two_q; // R12
        PIF_ADDR_IRQ_STAT:  rdata_d = {6'h00, stat_q};
        PIF_ADDR_IRQ_MASK:  rdata_d = {6'h00, mask_q};
        default:            rdata_d = PIF_RST_BYTE;
      endcase
    end
    // Gate flag not masked out: every request one bit, bit 7 included, counts with its enable
    any_req = |(req_one_view & en_one_q) | (req_two_q[0] & en_two_q[0]); // R14
    req_d = any_req && core_ctrl_q[PIF_BIT_PERIPH_EN] && core_ctrl_q[PIF_BIT_GLOBAL_EN]; // R13 R14
    irq_d = |(stat_d & mask_d);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_ctrl_q <= PIF_RST_BYTE;
      en_one_q    <= PIF_RST_BYTE;
      en_two_q    <= PIF_RST_BYTE;
      req_one_q   <= PIF_RST_BYTE;
      req_two_q   <= PIF_RST_BYTE;
      tx_empty_q  <= 1'b0;
      rx_full_q   <= 1'b0;
      stat_q      <= PIF_RST_STAT;
      mask_q      <= PIF_RST_STAT;
      rdata_q     <= PIF_RST_BYTE;
      req_q       <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      core_ctrl_q <= core_ctrl_d;
      en_one_q    <= en_one_d;
      en_two_q    <= en_two_d;
      req_one_q   <= req_one_d;
      req_two_q   <= req_two_d;
      tx_empty_q  <= tx_empty_d;
      rx_full_q   <= rx_full_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      rdata_q     <= rdata_d;
      req_q       <= req_d;
      irq_q       <= irq_d;
    end
  end

  assign rdata_o      = rdata_q;
  assign periph_req_o = req_q;
  assign irq_o        = irq_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_rd_en_two;
    rd_i && addr_i == PIF_ADDR_EN_TWO;
  endsequence

  sequence s_rd_req_two;
    rd_i && addr_i == PIF_ADDR_REQ_TWO;
  endsequence

  sequence s_wr_en_two;
    wr_i && addr_i == PIF_ADDR_EN_TWO;
  endsequence

  sequence s_wr_req_one;
    wr_i && addr_i == PIF_ADDR_REQ_ONE;
  endsequence

  sequence s_wr_stat;
    wr_i && addr_i == PIF_ADDR_IRQ_STAT;
  endsequence

  // Index seven is left unmapped on purpose
  sequence s_rd_unmapped;
    rd_i && addr_i == 3'h7;
  endsequence

  chk_en_two_upper: assert property (s_rd_en_two |=> rdata_o[7:1] == 7'h00) // R1
    else $error("upper enable two bits not zero");
  chk_flag_no_enable: assert property (t1_ovf_i |=> req_one_q[PIF_BIT_T1_OVF]) // R2 R11
    else $error("overflow flag missed");
  chk_conv_sticky: assert property (req_one_q[PIF_BIT_CONV_DONE] && !wr_i |=> req_one_q[PIF_BIT_CONV_DONE]) // R5
    else $error("conversion flag dropped");
  chk_rx_clear: assert property (rx_data_rd_i |=> !rx_full_q) // R6
    else $error("rx flag not cleared by read");
  chk_tx_clear: assert property (tx_data_wr_i |=> !tx_empty_q) // R7
    else $error("tx flag not cleared by write");
  chk_sync_set: assert property (sync_done_i |=> req_one_q[PIF_BIT_SYNC_DONE]) // R8
    else $error("sync flag missed");
  chk_pwm_unused: assert property (capcmp_one_pwm_i && !req_one_q[2] && !wr_i |=> !req_one_q[2]) // R9
    else $error("capture flag set in pwm mode");
  chk_match_set: assert property (t2_match_i |=> req_one_q[PIF_BIT_T2_MATCH]) // R10
    else $error("match flag missed");
  chk_two_set: assert property (capcmp_two_i && !capcmp_two_pwm_i |=> req_two_q[0]) // R12
    else $error("unit two flag missed");
  chk_req_gate: assert property (!core_ctrl_q[PIF_BIT_PERIPH_EN] |=> !periph_req_o) // R13
    else $error("request without peripheral enable");
  chk_req_cause: assert property (periph_req_o |-> $past(core_ctrl_q[PIF_BIT_GLOBAL_EN] && any_req)) // R14
    else $error("request without cause");

  // ****************************************
  // Enable and control register checks
  // ****************************************
  chk_en_two_store: assert property (s_wr_en_two |=> en_two_q == ($past(wdata_i) & PIF_EN_TWO_WMASK)) // R1
    else $error("enable two write not stored");
  chk_en_two_zero: assert property (en_two_q[7:1] == 7'h00) // R1
    else $error("enable two upper bits stored");
  chk_en_one_store: assert property (wr_i && addr_i == PIF_ADDR_EN_ONE |=> en_one_q == $past(wdata_i))
    else $error("enable one write not stored");
  chk_core_store: assert property (wr_i && addr_i == PIF_ADDR_CORE_CTRL |=> core_ctrl_q == $past(wdata_i)) // R13
    else $error("core control write not stored");
  chk_mask_store: assert property (wr_i && addr_i == PIF_ADDR_IRQ_MASK |=> mask_q == $past(wdata_i[1:0]))
    else $error("mask write not stored");

  // ****************************************
  // Request flag checks
  // ****************************************
  chk_gate_write: assert property (s_wr_req_one |=> req_one_q[PIF_BIT_GATE] == $past(wdata_i[PIF_BIT_GATE])) // R4
    else $error("gate flag write not stored");
  chk_gate_hold: assert property (!(wr_i && addr_i == PIF_ADDR_REQ_ONE) |=> $stable(req_one_q[PIF_BIT_GATE])) // R4
    else $error("gate flag changed without write");
  // Stored copies of the live bits must stay zero; reads and requests use rx_full_q and tx_empty_q instead
  chk_ro_bits: assert property (!req_one_q[PIF_BIT_RX_FULL] && !req_one_q[PIF_BIT_TX_EMPTY]) // R6 R7
    else $error("read-only request bits stored");
  chk_conv_set: assert property (conv_done_i |=> req_one_q[PIF_BIT_CONV_DONE]) // R2 R5
    else $error("conversion flag missed");
  chk_conv_clear: assert property (s_wr_req_one ##0 (!wdata_i[PIF_BIT_CONV_DONE] && !conv_done_i)
    |=> !req_one_q[PIF_BIT_CONV_DONE]) // R5
    else $error("conversion flag not cleared");
  chk_rx_follow: assert property (!rx_data_rd_i |=> rx_full_q == $past(rx_data_held_i)) // R6
    else $error("rx flag not following buffer");
  chk_tx_refill: assert property (!tx_data_wr_i |=> tx_empty_q) // R7
    else $error("tx flag not restored");
  chk_sync_sticky: assert property (req_one_q[PIF_BIT_SYNC_DONE] && !wr_i |=> req_one_q[PIF_BIT_SYNC_DONE]) // R8
    else $error("sync flag dropped");
  chk_sync_clear: assert property (s_wr_req_one ##0 (!wdata_i[PIF_BIT_SYNC_DONE] && !sync_done_i)
    |=> !req_one_q[PIF_BIT_SYNC_DONE]) // R8
    else $error("sync flag not cleared");
  chk_capcmp_set: assert property (capcmp_one_i && !capcmp_one_pwm_i |=> req_one_q[PIF_BIT_CAPCMP_ONE]) // R9
    else $error("unit one flag missed");
  chk_capcmp_clear: assert property (s_wr_req_one ##0 (!wdata_i[PIF_BIT_CAPCMP_ONE] && !capcmp_one_i)
    |=> !req_one_q[PIF_BIT_CAPCMP_ONE]) // R9
    else $error("unit one flag not cleared");
  chk_match_sticky: assert property (req_one_q[PIF_BIT_T2_MATCH] && !wr_i |=> req_one_q[PIF_BIT_T2_MATCH]) // R10
    else $error("match flag dropped");
  chk_match_clear: assert property (s_wr_req_one ##0 (!wdata_i[PIF_BIT_T2_MATCH] && !t2_match_i)
    |=> !req_one_q[PIF_BIT_T2_MATCH]) // R10
    else $error("match flag not cleared");
  chk_ovf_sticky: assert property (req_one_q[PIF_BIT_T1_OVF] && !wr_i |=> req_one_q[PIF_BIT_T1_OVF]) // R11
    else $error("overflow flag dropped");
  chk_ovf_clear: assert property (s_wr_req_one ##0 (!wdata_i[PIF_BIT_T1_OVF] && !t1_ovf_i)
    |=> !req_one_q[PIF_BIT_T1_OVF]) // R11
    else $error("overflow flag not cleared");
  chk_two_pwm: assert property (capcmp_two_pwm_i && !req_two_q[0] && !wr_i |=> !req_two_q[0]) // R12
    else $error("unit two flag set in pwm mode");
  chk_two_clear: assert property (wr_i && addr_i == PIF_ADDR_REQ_TWO && !wdata_i[0] && !capcmp_two_i
    |=> !req_two_q[0]) // R12
    else $error("unit two flag not cleared");
  chk_two_upper: assert property (s_rd_req_two |=> rdata_o[7:1] == 7'h00) // R12
    else $error("upper request two bits not zero");

  // ****************************************
  // Output checks
  // ****************************************
  chk_req_global: assert property (!core_ctrl_q[PIF_BIT_GLOBAL_EN] |=> !periph_req_o) // R14
    else $error("request without global enable");
  chk_req_set: assert property (core_ctrl_q[PIF_BIT_GLOBAL_EN] && core_ctrl_q[PIF_BIT_PERIPH_EN] && any_req
    |=> periph_req_o) // R14
    else $error("request missing");
  chk_stat_set: assert property (|set_one |=> stat_q[0])
    else $error("status event missed");
  chk_stat_clear: assert property (s_wr_stat ##0 (wdata_i[1] && !set_two) |=> !stat_q[1])
    else $error("status bit not cleared");
  // Interrupt is registered from the next status, so it changes on the same edge as stat_q and stays glitch free
  chk_irq_set: assert property (|(stat_d & mask_d) |=> irq_o)
    else $error("interrupt missing");
  chk_irq_clear: assert property (!(|(stat_d & mask_d)) |=> !irq_o)
    else $error("interrupt without cause");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == PIF_RST_BYTE)
    else $error("read data outside read cycle");
  chk_unmapped: assert property (s_rd_unmapped |=> rdata_o == PIF_RST_BYTE)
    else $error("unmapped index not zero");

endmodule : pif_irq_flags

// file: pif_pkg.sv
package pif_pkg;

  // ****************************************
  // Register indices on the plain port
  // ****************************************
  localparam logic [2:0] PIF_ADDR_CORE_CTRL = 3'h0;
  localparam logic [2:0] PIF_ADDR_EN_ONE    = 3'h1;
  localparam logic [2:0] PIF_ADDR_EN_TWO    = 3'h2;
  localparam logic [2:0] PIF_ADDR_REQ_ONE   = 3'h3;
  localparam logic [2:0] PIF_ADDR_REQ_TWO   = 3'h4;
  localparam logic [2:0] PIF_ADDR_IRQ_STAT  = 3'h5;
  localparam logic [2:0] PIF_ADDR_IRQ_MASK  = 3'h6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PIF_BIT_GLOBAL_EN  = 7;
  localparam int PIF_BIT_PERIPH_EN  = 6;
  localparam int PIF_BIT_GATE       = 7;
  localparam int PIF_BIT_CONV_DONE  = 6;
  localparam int PIF_BIT_RX_FULL    = 5;
  localparam int PIF_BIT_TX_EMPTY   = 4;
  localparam int PIF_BIT_SYNC_DONE  = 3;
  localparam int PIF_BIT_CAPCMP_ONE = 2;
  localparam int PIF_BIT_T2_MATCH   = 1;
  localparam int PIF_BIT_T1_OVF     = 0;
  localparam int PIF_BIT_CAPCMP_TWO = 0;

  // Bits software may write in the request registers and the second enable register
  localparam logic [7:0] PIF_REQ_ONE_WMASK = 8'hCF;
  localparam logic [7:0] PIF_REQ_TWO_WMASK = 8'h01;
  localparam logic [7:0] PIF_EN_TWO_WMASK  = 8'h01;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PIF_RST_BYTE = 8'h00;
  localparam logic [1:0] PIF_RST_STAT = 2'h0;

endpackage : pif_pkg

// file: test_pif_irq_flags.sv
`timescale 1ns/1ps
module test_pif_irq_flags;
  import pif_pkg::*;
  // ****************************************
  // Stimulus, monitor and verdict
  // ****************************************
  localparam logic [47:0] EVS = 48'h201008040201;
  localparam logic [47:0] EXP = 48'h501814121101;
  logic        core_clk_i = 1'h0, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, pend = 1'h0;
  logic        held = 1'h0, pwm1 = 1'h0, pwm2 = 1'h0, periph_req_o, irq_o;
  logic [2:0]  addr_i = 3'h0;
  logic [7:0]  wdata_i = 8'h00, ev = 8'h00, rdata_o, rnd;
  logic [15:0] q[$];
  int          errors = 0, check_count = 0, cyc = 0;

  pif_irq_flags i_pif_irq_flags (.core_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .gate_inactive_i(1'h0), .conv_done_i(ev[5]), .rx_data_held_i(held), .tx_data_wr_i(ev[7]),
    .rx_data_rd_i(ev[6]), .sync_done_i(ev[4]), .capcmp_one_i(ev[3]), .capcmp_one_pwm_i(pwm1),
    .t2_match_i(ev[2]), .t1_ovf_i(ev[1]), .capcmp_two_i(ev[0]), .capcmp_two_pwm_i(pwm2),
    .periph_req_o, .irq_o);

  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Reads carry the expected byte in d and a compare mask in m
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk_i);
    wr_i    <= w;
    rd_i    <= r;
    addr_i  <= a;
    wdata_i <= d;
    ev      <= e;
    if (r) q.push_back({m, d});
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'h1, 1'h0, a, d, 8'h00, 8'h00);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'h0, 1'h1, a, e, 8'h00, m);
  endtask : rd

  task automatic idle(input logic [7:0] e);
    bus(1'h0, 1'h0, 3'h0, 8'h00, e, 8'h00);
  endtask : idle

  // The request is registered twice behind a write and the interrupt once, so let three edges pass
  task automatic lvl(input logic p, input logic i);
    repeat (3) idle(8'h00);
    #1;
    chk({6'h00, periph_req_o, irq_o}, {6'h00, p, i}, "req_irq");
  endtask : lvl

  initial forever #12.5 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    if (pend) begin
      chk(rdata_o & q[0][15:8], q[0][7:0] & q[0][15:8], "rdata");
      void'(q.pop_front());
    end
    pend <= rd_i;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    rnd = $urandom(73);
    repeat (5) @(posedge core_clk_i);
    rstn_i <= 1'h1;
    wr(3'h7, 8'hFF);
    for (int a = 1; a < 8; a++) rd(3'(a), 8'h00, (a == 5) ? 8'h02 : (a == 3) ? 8'hEF : 8'hFF);
    wr(PIF_ADDR_EN_TWO, 8'hFF);
    rd(PIF_ADDR_EN_TWO, 8'h01, 8'hFF);
    rnd = 8'($urandom);
    wr(PIF_ADDR_EN_TWO, rnd);
    rd(PIF_ADDR_EN_TWO, rnd & 8'h01, 8'hFF);
    rnd = 8'($urandom);
    wr(PIF_ADDR_EN_ONE, rnd);
    rd(PIF_ADDR_EN_ONE, rnd, 8'hFF);
    wr(PIF_ADDR_EN_ONE, 8'h00);
    // Clearing write in the event cycle: the event must still land
    for (int i = 0; i < 6; i++) begin
      bus(1'h1, 1'h0, (i == 5) ? PIF_ADDR_REQ_TWO : PIF_ADDR_REQ_ONE, 8'h00, EVS[47-8*i-:8], 8'h00);
      rd((i == 5) ? PIF_ADDR_REQ_TWO : PIF_ADDR_REQ_ONE, EXP[47-8*i-:8], 8'hFF);
      wr((i == 5) ? PIF_ADDR_REQ_TWO : PIF_ADDR_REQ_ONE, 8'h00);
    end
    pwm1 <= 1'h1;
    pwm2 <= 1'h1;
    idle(8'h09);
    rd(PIF_ADDR_REQ_ONE, 8'h10, 8'hFF);
    rd(PIF_ADDR_REQ_TWO, 8'h00, 8'hFF);
    pwm1 <= 1'h0;
    pwm2 <= 1'h0;
    wr(PIF_ADDR_REQ_ONE, 8'hFF);
    rd(PIF_ADDR_REQ_ONE, 8'hDF, 8'hFF);
    wr(PIF_ADDR_REQ_ONE, 8'h00);
    held <= 1'h1;
    idle(8'h00);
    rd(PIF_ADDR_REQ_ONE, 8'h30, 8'hFF);
    held <= 1'h0;
    idle(8'h40);
    rd(PIF_ADDR_REQ_ONE, 8'h10, 8'hFF);
    idle(8'h80);
    rd(PIF_ADDR_REQ_ONE, 8'h00, 8'h10);
    rd(PIF_ADDR_REQ_ONE, 8'h10, 8'h10);
    wr(PIF_ADDR_REQ_ONE, 8'h00);
    wr(PIF_ADDR_EN_ONE, 8'h01);
    idle(8'h02);
    wr(PIF_ADDR_CORE_CTRL, 8'h40);
    rd(PIF_ADDR_CORE_CTRL, 8'h40, 8'hC0);
    lvl(1'h0, 1'h0);
    wr(PIF_ADDR_CORE_CTRL, 8'hC0);
    lvl(1'h1, 1'h0);
    rd(PIF_ADDR_IRQ_STAT, 8'h02, 8'h02);
    wr(PIF_ADDR_IRQ_MASK, 8'h02);
    lvl(1'h1, 1'h1);
    wr(PIF_ADDR_IRQ_STAT, 8'h02);
    lvl(1'h1, 1'h0);
    idle(8'h01);
    lvl(1'h1, 1'h1);
    wr(PIF_ADDR_IRQ_MASK, 8'h00);
    lvl(1'h1, 1'h0);
    wr(PIF_ADDR_CORE_CTRL, 8'h80);
    lvl(1'h0, 1'h0);
    close_out();
  end
endmodule : test_pif_irq_flags
